// [logic/conv_opts_reg.sv]
// Conversion options register block with its serial command port.
// Assumes SCLK idles low, CS_N low frames commands, CLK_SYS is tclk.
//
// Notes on behaviour
// [R01] Serial port times out after long SCLK low
// [R02] Timeout enable bit zero, enabled at reset
// [R03] Sum enable appends checksum byte to readback
// [R04] Filter bit picks first or second order
// [R05] Delay code sets start-to-conversion wait
// [R06] Options register resets to 0x08
// [R07] Host starts conversions with the start command
// [R08] Range option replaces data LSB with flag
`timescale 1ns/100ps
module conv_opts_reg
	import conv_opts_pkg::*;
#(
	parameter int TMO_CYCLES = 2 ** TMO_EXP
)
(
	input  wire logic        CLK_SYS_I,
	input  wire logic        RESET_N_I,
	input  wire logic        SCLK_I,
	input  wire logic        CS_N_I,
	input  wire logic        DIN_I,
	input  wire logic [23:0] CONV_DATA_I,
	input  wire logic        OUT_OF_RANGE_I,
	output logic             DOUT_O,
	output logic             CONV_BEGIN_O,
	output logic             FILTER_ORDER_O,
	output logic             REF_SOURCE_O,
	output logic             SPI_TIMEOUT_O
);

	// -------------------------------------------------------------
	// Declarations
	// -------------------------------------------------------------
	logic [1:0]           rst_q;
	logic                 rst_n_q;
	logic [2:0]           sync_s;
	logic                 tog_p_q;
	logic                 byte_ev;
	logic                 cs_s;
	logic                 sclk_s;
	logic [2:0]           bit_cnt_q;
	logic [6:0]           rx_sh_q;
	logic [7:0]           rx_byte_q;
	logic                 rx_tog_q;
	logic [6:0]           tx_sh_q;
	logic                 frame_rst_n;
	logic                 tmo_hold_q;
	logic [TMO_CNT_W-1:0] tmo_cnt_q;
	logic                 tmo_en_q;
	logic [7:0]           opts_q;
	dec_state_e           st_q;
	logic                 wr_q;
	logic [3:0]           addr_q;
	logic [3:0]           cnt_q;
	logic [2:0]           idx_q;
	logic [7:0]           tx_q;
	logic [23:0]          data_q;
	logic [7:0]           sum_q;
	logic                 start_q;
	logic [DLY_CNT_W-1:0] dly_cnt_q;
	logic                 counting;
	logic                 wr_ev;

	// Register read decode
	function automatic logic [7:0] reg_read(input logic [3:0] a,
		input logic t, input logic [7:0] o);
		logic [7:0] v;
		v = 8'h00;
		if (a == ADDR_TIMEOUT_CFG)
			v = TMO_CFG_FIXED | {7'h00, t};
		else if (a == ADDR_CONV_OPTIONS)
			v = o;
		return v;
	endfunction : reg_read

	// Delay code to master clock periods
	function automatic logic [DLY_CNT_W-1:0] dly_cycles(
		input logic [2:0] code);
		logic [DLY_CNT_W-1:0] v;
		v = '0;
		if (code != 3'h0)
			v = DLY_CNT_W'(DLY_BASE_CYC) << (code - 3'h1);
		return v;
	endfunction : dly_cycles

	// -------------------------------------------------------------
	// Reset and synchronisers
	// -------------------------------------------------------------
	// Reset release through two flops
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			rst_q <= 2'h0;
		else
			rst_q <= {rst_q[0], 1'b1};
	end
	assign rst_n_q = rst_q[1];

	bit_sync #(.WIDTH(3)) u_sync
	(
		.clk_i   (CLK_SYS_I),
		.rst_n_i (rst_n_q),
		.async_i ({CS_N_I, SCLK_I, rx_tog_q}),
		.sync_o  (sync_s)
	);
	assign cs_s   = sync_s[2];
	assign sclk_s = sync_s[1];

	// Byte arrival edge from toggle
	always_ff @(posedge CLK_SYS_I or negedge rst_n_q)
	begin
		if (!rst_n_q)
			tog_p_q <= 1'b0;
		else
			tog_p_q <= sync_s[0];
	end
	assign byte_ev = (sync_s[0] ^ tog_p_q) & ~cs_s;

	// -------------------------------------------------------------
	// Link side, clocked by SCLK
	// -------------------------------------------------------------
	// Framing restarts on deselect or timeout
	assign frame_rst_n = rst_n_q & ~CS_N_I & ~tmo_hold_q;

	// Shift in bits, MSB first
	always_ff @(posedge SCLK_I or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
		begin
			bit_cnt_q <= 3'h0;
			rx_sh_q   <= 7'h00;
		end
		else
		begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
			rx_sh_q   <= {rx_sh_q[5:0], DIN_I};
		end
	end

	// Completed byte held for eight SCLK periods
	always_ff @(posedge SCLK_I or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			rx_byte_q <= 8'h00;
			rx_tog_q  <= 1'b0;
		end
		else if (frame_rst_n && bit_cnt_q == 3'h7)
		begin
			rx_byte_q <= {rx_sh_q, DIN_I};
			rx_tog_q  <= ~rx_tog_q;
		end
	end

	// Shift out on falling edges; tx_q is stable here
	always_ff @(negedge SCLK_I or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
		begin
			DOUT_O  <= 1'b0;
			tx_sh_q <= 7'h00;
		end
		else if (bit_cnt_q == 3'h1)
		begin
			DOUT_O  <= tx_q[7];
			tx_sh_q <= tx_q[6:0];
		end
		else
		begin
			DOUT_O  <= tx_sh_q[6];
			tx_sh_q <= {tx_sh_q[5:0], 1'b0};
		end
	end

	// -------------------------------------------------------------
	// Serial clock timeout
	// -------------------------------------------------------------
	// Count stops and clears to zero while framing is held after a timeout
	assign counting = tmo_en_q & ~sclk_s & ~cs_s & ~tmo_hold_q;

	// [R01] Count SCLK low time
	always_ff @(posedge CLK_SYS_I or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			tmo_cnt_q     <= '0;
			SPI_TIMEOUT_O <= 1'b0;
		end
		else if (counting && int'(tmo_cnt_q) < TMO_CYCLES - 1)
		begin
			tmo_cnt_q     <= tmo_cnt_q + TMO_CNT_W'(1);
			SPI_TIMEOUT_O <= 1'b0;
		end
		else
		begin
			// At the limit: one pulse, then restart the count
			SPI_TIMEOUT_O <= counting;
			tmo_cnt_q     <= '0;
		end
	end

	// Hold framing reset until SCLK rises or deselect
	always_ff @(posedge CLK_SYS_I or negedge rst_n_q)
	begin
		if (!rst_n_q)
			tmo_hold_q <= 1'b0;
		else if (SPI_TIMEOUT_O)
			tmo_hold_q <= 1'b1;
		else if (sclk_s || cs_s)
			tmo_hold_q <= 1'b0;
	end

	// -------------------------------------------------------------
	// Registers
	// -------------------------------------------------------------
	assign wr_ev = byte_ev & (st_q == ST_WR);

	// [R02] Timeout enable, on at reset
	always_ff @(posedge CLK_SYS_I or negedge rst_n_q)
	begin
		if (!rst_n_q)
			tmo_en_q <= TMO_EN_RESET;
		else if (wr_ev && addr_q == ADDR_TIMEOUT_CFG)
			tmo_en_q <= rx_byte_q[TMO_EN_BIT];
	end

	// [R06] Options byte reset value
	always_ff @(posedge CLK_SYS_I or negedge rst_n_q)
	begin
		if (!rst_n_q)
			opts_q <= OPTS_RESET;
		else if (wr_ev && addr_q == ADDR_CONV_OPTIONS)
			opts_q <= rx_byte_q & OPTS_WRITE_MASK;
	end

	// -------------------------------------------------------------
	// Command decoder
	// -------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			st_q    <= ST_IDLE;
			wr_q    <= 1'b0;
			addr_q  <= 4'h0;
			cnt_q   <= 4'h0;
			idx_q   <= 3'h0;
			tx_q    <= 8'h00;
			data_q  <= 24'h000000;
			sum_q   <= 8'h00;
			start_q <= 1'b0;
		end
		else if (cs_s || SPI_TIMEOUT_O)
		begin
			st_q    <= ST_IDLE;
			tx_q    <= 8'h00;
			start_q <= 1'b0;
		end
		else
		begin
			start_q <= 1'b0;
			if (byte_ev)
			begin
				case (st_q)
				ST_IDLE:
				begin
					addr_q <= rx_byte_q[3:0];
					if (rx_byte_q[7:4] == OPC_RREG_HI ||
						rx_byte_q[7:4] == OPC_WREG_HI)
					begin
						wr_q <= rx_byte_q[7:4] == OPC_WREG_HI;
						st_q <= ST_CNT;
					end
					else if (rx_byte_q == OPC_RDATA)
					begin
						// [R08] Range flag into LSB
						data_q <= {CONV_DATA_I[23:1], opts_q[RANGE_BIT] ?
							OUT_OF_RANGE_I : CONV_DATA_I[0]};
						sum_q  <= CONV_DATA_I[23:16] + CONV_DATA_I[15:8] +
							{CONV_DATA_I[7:1], opts_q[RANGE_BIT] ?
							OUT_OF_RANGE_I : CONV_DATA_I[0]};
						tx_q   <= CONV_DATA_I[23:16];
						idx_q  <= 3'h1;
						st_q   <= ST_DATA;
					end
					else if (rx_byte_q == OPC_START)
						start_q <= 1'b1;
				end
				ST_CNT:
				begin
					cnt_q <= rx_byte_q[3:0];
					if (wr_q)
						st_q <= ST_WR;
					else
					begin
						tx_q <= reg_read(addr_q, tmo_en_q, opts_q);
						st_q <= ST_RD;
					end
				end
				ST_WR, ST_RD:
				begin
					if (cnt_q == 4'h0)
					begin
						st_q <= ST_IDLE;
						tx_q <= 8'h00;
					end
					else
					begin
						cnt_q  <= cnt_q - 4'h1;
						addr_q <= addr_q + 4'h1;
						tx_q   <= reg_read(addr_q + 4'h1, tmo_en_q, opts_q);
					end
				end
				ST_DATA:
				begin
					idx_q <= idx_q + 3'h1;
					if (idx_q == 3'h1)
						tx_q <= data_q[15:8];
					else if (idx_q == 3'h2)
						tx_q <= data_q[7:0];
					// [R03] Optional checksum byte
					else if (idx_q == 3'h3 && opts_q[SUM_EN_BIT])
						tx_q <= sum_q;
					else
					begin
						tx_q <= 8'h00;
						st_q <= ST_IDLE;
					end
				end
				default:
					st_q <= ST_IDLE;
				endcase
			end
		end
	end

	// -------------------------------------------------------------
	// Start delay and conversion options
	// -------------------------------------------------------------
	// [R05] Delay from start trigger
	always_ff @(posedge CLK_SYS_I or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			dly_cnt_q    <= '0;
			CONV_BEGIN_O <= 1'b0;
		end
		else if (start_q)
		begin
			dly_cnt_q    <= dly_cycles(opts_q[DELAY_LSB +: DELAY_W]);
			CONV_BEGIN_O <= opts_q[DELAY_LSB +: DELAY_W] == 3'h0;
		end
		else
		begin
			dly_cnt_q    <= (dly_cnt_q != '0) ? dly_cnt_q - 1'b1 : '0;
			CONV_BEGIN_O <= dly_cnt_q == DLY_CNT_W'(1);
		end
	end

	// [R04] Filter order taken at conversion begin
	always_ff @(posedge CLK_SYS_I or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			FILTER_ORDER_O <= OPTS_RESET[FILTER_BIT];
			REF_SOURCE_O   <= OPTS_RESET[REF_BIT];
		end
		else
		begin
			REF_SOURCE_O <= opts_q[REF_BIT];
			if ((start_q && opts_q[DELAY_LSB +: DELAY_W] == 3'h0) ||
				(!start_q && dly_cnt_q == DLY_CNT_W'(1)))
				FILTER_ORDER_O <= opts_q[FILTER_BIT];
		end
	end

	// -------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------
	logic [DLY_CNT_W-1:0] el_q;
	logic [DLY_CNT_W-1:0] exp_q;
	logic                 first_q;

	// Elapsed time since last start trigger
	always_ff @(posedge CLK_SYS_I or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			el_q    <= '0;
			exp_q   <= '0;
			first_q <= 1'b1;
		end
		else
		begin
			first_q <= 1'b0;
			el_q    <= start_q ? DLY_CNT_W'(1) : el_q + 1'b1;
			if (start_q)
				exp_q <= dly_cycles(opts_q[DELAY_LSB +: DELAY_W]) + 1'b1;
		end
	end

	// [R01] Timeout fires at the limit
	property p_tmo_limit; // [R01]
		@(posedge CLK_SYS_I) disable iff (!rst_n_q)
		SPI_TIMEOUT_O |-> int'($past(tmo_cnt_q)) == TMO_CYCLES - 1;
	endproperty
	a_tmo_limit: assert property (p_tmo_limit) // [R01]
		else $error("timeout fired before the limit");

	// [R02] Disabled timeout never fires
	property p_tmo_off; // [R02]
		@(posedge CLK_SYS_I) disable iff (!rst_n_q)
		!$past(tmo_en_q) |-> !SPI_TIMEOUT_O;
	endproperty
	a_tmo_off: assert property (p_tmo_off) // [R02]
		else $error("timeout fired while disabled");

	// [R03] Sum byte or end of readback
	property p_sum_byte; // [R03]
		@(posedge CLK_SYS_I) disable iff (!rst_n_q)
		(byte_ev && !cs_s && st_q == ST_DATA && idx_q == 3'h3) |=>
			(opts_q[SUM_EN_BIT] ? tx_q == sum_q : st_q == ST_IDLE);
	endproperty
	a_sum_byte: assert property (p_sum_byte) // [R03]
		else $error("checksum byte handling wrong");

	// [R04] Filter order follows option at begin
	property p_filter; // [R04]
		@(posedge CLK_SYS_I) disable iff (!rst_n_q)
		CONV_BEGIN_O |-> FILTER_ORDER_O == $past(opts_q[FILTER_BIT]);
	endproperty
	a_filter: assert property (p_filter) // [R04]
		else $error("filter order not taken at begin");

	// [R05] Begin exactly after programmed delay
	property p_delay; // [R05]
		@(posedge CLK_SYS_I) disable iff (!rst_n_q)
		CONV_BEGIN_O |-> el_q == exp_q;
	endproperty
	a_delay: assert property (p_delay) // [R05]
		else $error("conversion begin at wrong time");

	// [R06] Options reset value
	property p_opts_reset; // [R06]
		@(posedge CLK_SYS_I) disable iff (!rst_n_q)
		first_q |-> opts_q == OPTS_RESET && tmo_en_q;
	endproperty
	a_opts_reset: assert property (p_opts_reset) // [R06]
		else $error("options not at reset value");

	// [R08] Range flag lands in data LSB
	property p_range; // [R08]
		@(posedge CLK_SYS_I) disable iff (!rst_n_q)
		(byte_ev && !cs_s && st_q == ST_IDLE && rx_byte_q == OPC_RDATA &&
			opts_q[RANGE_BIT]) |=> data_q[0] == $past(OUT_OF_RANGE_I);
	endproperty
	a_range: assert property (p_range) // [R08]
		else $error("range flag not placed in data");

endmodule : conv_opts_reg

// [logic/conv_opts_pkg.sv]
// Package: constants for the conversion options register block.
// Assumes a 50 MHz master clock and a byte-wide serial command port.
package conv_opts_pkg;

	// -------------------------------------------------------------
	// Register map
	// -------------------------------------------------------------
	localparam logic [3:0] ADDR_TIMEOUT_CFG   = 4'h0;
	localparam logic [3:0] ADDR_CONV_OPTIONS  = 4'h1;
	localparam logic [7:0] OPTS_RESET         = 8'h08;
	localparam logic [7:0] OPTS_WRITE_MASK    = 8'hdf;
	localparam logic       TMO_EN_RESET       = 1'b1;
	// Fixed read pattern of the timeout register, bit 0 overlaid
	localparam logic [7:0] TMO_CFG_FIXED      = 8'h84;

	// -------------------------------------------------------------
	// Field positions
	// -------------------------------------------------------------
	localparam int TMO_EN_BIT    = 0;
	localparam int RANGE_BIT     = 7;
	localparam int SUM_EN_BIT    = 6;
	localparam int FILTER_BIT    = 4;
	localparam int REF_BIT       = 3;
	localparam int DELAY_LSB     = 0;
	localparam int DELAY_W       = 3;

	// -------------------------------------------------------------
	// Command opcodes
	// -------------------------------------------------------------
	localparam logic [3:0] OPC_RREG_HI = 4'h2;
	localparam logic [3:0] OPC_WREG_HI = 4'h4;
	localparam logic [7:0] OPC_RDATA   = 8'h12;
	localparam logic [7:0] OPC_START   = 8'h08;

	// -------------------------------------------------------------
	// Timing
	// -------------------------------------------------------------
	localparam int TMO_EXP        = 16;
	localparam int TMO_CNT_W      = 17;
	localparam int DLY_BASE_TCLK  = 64;
	localparam int CLK_PER_TCLK   = 1;
	localparam int DLY_BASE_CYC   = DLY_BASE_TCLK * CLK_PER_TCLK;
	localparam int DLY_CNT_W      = 13;

	// Command decoder states
	typedef enum logic [4:0]
	{
		ST_IDLE = 5'b00001,
		ST_CNT  = 5'b00010,
		ST_WR   = 5'b00100,
		ST_RD   = 5'b01000,
		ST_DATA = 5'b10000
	} dec_state_e;

endpackage : conv_opts_pkg

// [logic/bit_sync.sv]
// Two-stage synchroniser for a group of independent levels.
// Assumes each bit is a slow level or a toggle, never a coded word.
`timescale 1ns/100ps
module bit_sync
#(
	parameter int WIDTH = 3
)
(
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_q <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule : bit_sync

// [bench/spi_host_model.sv]
// Host serial master model for the conversion options port.
// Assumes the device samples DIN on SCLK rise and shifts DOUT on fall.
`timescale 1ns/100ps
module spi_host_model
	import conv_opts_pkg::*;
(
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      din_o,
	input  wire logic dout_i
);
	localparam int HALF = 80;
	logic [7:0] sh;

	// Idle: clock still and low, select released
	initial
	begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		din_o  = 1'b0;
		sh     = 8'h00;
	end

	// Select low well ahead of the first clock edge
	task automatic open_frame();
		cs_n_o = 1'b0;
		#200;
	endtask : open_frame

	// Release select; data line no longer holds its last value
	task automatic close_frame();
		#200;
		cs_n_o = 1'b1;
		din_o  = ~din_o;
		#400;
	endtask : close_frame

	// One byte MSB first; r is the reply to the byte before
	task automatic xfer(input logic [7:0] b, output logic [7:0] r);
		r = 8'h00;
		for (int i = 7; i >= 0; i--)
		begin
			din_o = b[i];
			#HALF;
			sclk_o = 1'b1;
			sh = {sh[6:0], dout_i};
			if (i == 7)
				r = sh;
			#HALF;
			sclk_o = 1'b0;
		end
	endtask : xfer

	task automatic start_cmd();
		logic [7:0] r;
		open_frame();
		xfer(OPC_START, r);
		close_frame();
	endtask : start_cmd

endmodule : spi_host_model

// [bench/conv_opts_reg_tb_top.sv]
// Testbench for the conversion options register block.
// Assumes spi_host_model drives the serial port as the host.
`timescale 1ns/100ps
module conv_opts_reg_tb_top
	import conv_opts_pkg::*;
;
	logic        CLK_SYS_I      = 1'b0;
	logic        RESET_N_I      = 1'b0;
	logic [23:0] CONV_DATA_I    = 24'h123456;
	logic        OUT_OF_RANGE_I = 1'b1;
	wire logic   sclk, cs_n, din;
	logic        dout, conv_begin, filt, ref_src, tmo, filt_at;
	int          fails      = 0;
	int          n_compared = 0;
	int          cyc        = 0;
	int          n_tmo      = 0;
	int          n_beg      = 0;
	int          beg_at     = 0;

	always #10 CLK_SYS_I = ~CLK_SYS_I;

	conv_opts_reg #(.TMO_CYCLES(64)) conv_opts_reg_inst (
		.CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I), .SCLK_I(sclk),
		.CS_N_I(cs_n), .DIN_I(din), .CONV_DATA_I(CONV_DATA_I),
		.OUT_OF_RANGE_I(OUT_OF_RANGE_I), .DOUT_O(dout),
		.CONV_BEGIN_O(conv_begin), .FILTER_ORDER_O(filt),
		.REF_SOURCE_O(ref_src), .SPI_TIMEOUT_O(tmo));

	spi_host_model spi_host_model_inst (
		.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout));

	// Verdict and end of run
	task automatic end_of_test();
		if (fails == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	// Byte comparison
	task automatic chk8(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_compared++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk8

	// Count comparison within a window
	task automatic chk_rng(input string nm, input int lo, input int hi,
		input int g);
		n_compared++;
		if (g < lo || g > hi)
		begin
			fails++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask : chk_rng

	// Single register read, value returned during the dummy byte
	task automatic rreg(input logic [3:0] a, output logic [7:0] v);
		logic [7:0] r;
		spi_host_model_inst.open_frame();
		spi_host_model_inst.xfer({OPC_RREG_HI, a}, r);
		spi_host_model_inst.xfer(8'h00, r);
		spi_host_model_inst.xfer(8'h00, r);
		spi_host_model_inst.xfer(8'h00, v);
		spi_host_model_inst.close_frame();
	endtask : rreg

	// Single register write
	task automatic wreg(input logic [3:0] a, input logic [7:0] v);
		logic [7:0] r;
		spi_host_model_inst.open_frame();
		spi_host_model_inst.xfer({OPC_WREG_HI, a}, r);
		spi_host_model_inst.xfer(8'h00, r);
		spi_host_model_inst.xfer(v, r);
		spi_host_model_inst.close_frame();
	endtask : wreg

	// Data readback: three data bytes and the optional sum byte
	task automatic rdata(output logic [7:0] q [4]);
		logic [7:0] r;
		spi_host_model_inst.open_frame();
		spi_host_model_inst.xfer(OPC_RDATA, r);
		spi_host_model_inst.xfer(8'h00, r);
		for (int i = 0; i < 4; i++)
			spi_host_model_inst.xfer(8'h00, q[i]);
		spi_host_model_inst.close_frame();
	endtask : rdata

	// Cycle count, output events and hang limit
	always @(posedge CLK_SYS_I)
	begin
		cyc <= cyc + 1;
		if (tmo === 1'b1)
			n_tmo <= n_tmo + 1;
		if (conv_begin === 1'b1)
		begin
			n_beg   <= n_beg + 1;
			beg_at  <= cyc;
			filt_at <= filt;
		end
		if (cyc > 40000)
		begin
			fails++;
			end_of_test();
		end
	end

	// Main sequence
	initial
	begin
		logic [7:0] v;
		logic [7:0] q [4];
		logic [2:0] code;
		int         t, d, nb;
		repeat (8) @(posedge CLK_SYS_I);
		RESET_N_I <= 1'b1;
		repeat (10) @(posedge CLK_SYS_I);
		#7;
		chk8("filter", 8'h00, {7'h0, filt});
		chk8("ref", 8'h01, {7'h0, ref_src});
		rreg(ADDR_CONV_OPTIONS, v);
		chk8("opts", OPTS_RESET, v);
		rreg(ADDR_TIMEOUT_CFG, v);
		chk8("tmo_cfg", 8'h85, v);
		// Two-register read with address increment
		spi_host_model_inst.open_frame();
		spi_host_model_inst.xfer({OPC_RREG_HI, ADDR_TIMEOUT_CFG}, v);
		spi_host_model_inst.xfer(8'h01, v);
		spi_host_model_inst.xfer(8'h00, v);
		spi_host_model_inst.xfer(8'h00, v);
		chk8("burst0", 8'h85, v);
		spi_host_model_inst.xfer(8'h00, v);
		chk8("burst1", OPTS_RESET, v);
		spi_host_model_inst.close_frame();
		wreg(ADDR_CONV_OPTIONS, 8'hff);
		rreg(ADDR_CONV_OPTIONS, v);
		chk8("opts_w", 8'hdf, v);
		wreg(4'h5, 8'hff);
		rreg(4'h5, v);
		chk8("unmapped", 8'h00, v);
		wreg(ADDR_CONV_OPTIONS, 8'h07);
		chk8("ref_int", 8'h00, {7'h0, ref_src});
		rdata(q);
		chk8("d2", 8'h12, q[0]);
		chk8("d1", 8'h34, q[1]);
		chk8("d0", 8'h56, q[2]);
		chk8("nosum", 8'h00, q[3]);
		wreg(ADDR_CONV_OPTIONS, 8'hc0);
		rdata(q);
		chk8("d2f", 8'h12, q[0]);
		chk8("d0f", 8'h57, q[2]);
		chk8("sum", 8'h9d, q[3]);
		for (int c = 0; c < 8; c++)
		begin
			code = 3'(c);
			wreg(ADDR_CONV_OPTIONS, {3'h0, code[0], 1'b0, code});
			nb = n_beg;
			spi_host_model_inst.start_cmd();
			t = cyc - 34;
			d = (c == 0) ? 1 : (64 << (c - 1)) + 1;
			for (int k = 0; k < 4300 && n_beg == nb; k++)
				@(posedge CLK_SYS_I);
			#7;
			chk_rng("delay", d + 1, d + 6, beg_at - t);
			chk8("filt_at", {7'h0, code[0]}, {7'h0, filt_at});
		end
		d = n_tmo;
		spi_host_model_inst.open_frame();
		repeat (45) @(posedge CLK_SYS_I);
		chk_rng("tmo_early", d, d, n_tmo);
		repeat (40) @(posedge CLK_SYS_I);
		chk_rng("tmo", d + 1, d + 1, n_tmo);
		#7;
		spi_host_model_inst.close_frame();
		wreg(ADDR_TIMEOUT_CFG, 8'h00);
		spi_host_model_inst.open_frame();
		repeat (150) @(posedge CLK_SYS_I);
		chk_rng("tmo_off", d + 1, d + 1, n_tmo);
		#7;
		spi_host_model_inst.close_frame();
		rreg(ADDR_TIMEOUT_CFG, v);
		chk8("tmo_cfg_w", 8'h84, v);
		end_of_test();
	end

endmodule : conv_opts_reg_tb_top
